// ---- core/hwd_pkg.sv ----
// constants for the host watchdog command port: request codes, item numbers,
// frame layout, reply codes and timing.
// assumes a byte-wide receiver/transmitter and a frame-gap detector outside.
//
// Operation
// - expiry flag read is function 0x01, item 0x010D, quantity 1; one-byte reply.
// - flag reply data byte is 0x00 when clear, 0x01 when expired.
// - period holds 0 to 255 tenths of a second; upper byte reads zero.
// - function 0x03 or 0x04 at 0x3038 value 0 is host alive; never answered.
// - function 0x05 at item 0x0104 enables with 0xFF00, disables with 0x0000.
// - function 0x05 at item 0x010D with 0xFF00 clears the expiry flag.
// - a good function 0x05 write is echoed unchanged.
// - function 0x06 at 0x01E8 stores a period from 0x0000 to 0x00FF.
// - a good function 0x06 write is echoed unchanged.
// - failures reply with function plus 0x80 and one exception code byte.
package hwd_pkg;

    // function codes
    localparam logic [7:0] FC_READ_BITS = 8'h01;
    localparam logic [7:0] FC_READ_HOLD = 8'h03;
    localparam logic [7:0] FC_READ_INPUT = 8'h04;
    localparam logic [7:0] FC_WRITE_BIT = 8'h05;
    localparam logic [7:0] FC_WRITE_REG = 8'h06;
    localparam logic [7:0] FC_ERROR_FLAG = 8'h80;

    // item and register numbers
    localparam logic [15:0] ITEM_ENABLE = 16'h0104;
    localparam logic [15:0] ITEM_EXPIRY = 16'h010d;
    localparam logic [15:0] REG_PERIOD = 16'h01e8;
    localparam logic [15:0] REG_ALIVE = 16'h3038;

    // values
    localparam logic [15:0] VAL_ON = 16'hff00;
    localparam logic [15:0] VAL_OFF = 16'h0000;
    localparam logic [15:0] VAL_ALIVE = 16'h0000;
    localparam logic [15:0] QTY_ONE = 16'h0001;
    localparam logic [15:0] PERIOD_MAX = 16'h00ff;
    localparam logic [7:0] FLAG_CLEAR_BYTE = 8'h00;
    localparam logic [7:0] FLAG_SET_BYTE = 8'h01;
    localparam logic [7:0] BYTES_FLAG = 8'h01;
    localparam logic [7:0] BYTES_PERIOD = 8'h02;

    // standard exception codes
    localparam logic [7:0] EXC_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;

    // slave address range
    localparam logic [7:0] ADDR_MIN = 8'h01;
    localparam logic [7:0] ADDR_MAX = 8'hf7;

    // frame layout: every request here is eight bytes, crc included
    localparam int unsigned FRAME_LEN = 8;
    localparam logic [3:0] FRAME_LEN_B = 4'h8;
    localparam logic [3:0] LEN_EXC = 4'h3;
    localparam logic [3:0] LEN_FLAG = 4'h4;
    localparam logic [3:0] LEN_PERIOD = 4'h5;
    localparam logic [3:0] LEN_ECHO = 4'h6;

    // crc-16 as used on the serial link
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    // reset values
    localparam logic [7:0] PERIOD_RST = 8'h00;
    localparam logic ENABLE_RST = 1'b0;

    // timing: one period unit is 100 ms at a 250 MHz clock
    localparam int unsigned CLOCK_MHZ = 250;
    localparam int unsigned UNIT_MS = 100;
    localparam int unsigned TICK_CYCLES_DFLT = UNIT_MS * 1000 * CLOCK_MHZ;

    // transmit sequencer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_SEND
    } hwd_state_t;

endpackage : hwd_pkg

// ---- core/hwd_crc16.sv ----
// byte-serial crc-16 accumulator for the serial frames.
// assumes bytes arrive one per cycle at most on the same clock.
module hwd_crc16 (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // byte stream
    input wire logic i_clear,
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    // running value
    output logic [15:0] o_crc
);
    import hwd_pkg::*;

    logic [15:0] crc_r;
    logic [15:0] crc_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // one byte folded in, lsb first, as the link does it
    always_comb begin
        crc_nxt = crc_r ^ {8'h00, i_data};
        for (int b = 0; b < 8; b++) begin
            crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ CRC_POLY) : (crc_nxt >> 1);
        end
    end

    // clear wins so a new frame never inherits the old tail
    always_ff @(posedge i_clock) begin
        if (i_rst || i_clear) begin
            crc_r <= CRC_INIT;
        end else if (i_valid) begin
            crc_r <= crc_nxt;
        end
    end

    assign o_crc = crc_r;

endmodule : hwd_crc16

// ---- core/hwd_watchdog.sv ----
// host watchdog with its command port: decodes eight-byte requests from
// the serial link, runs the supervision timer and sends the replies.
// assumes a receiver giving bytes and a frame-end pulse after the gap,
// and a transmitter taking one byte per valid/ready handshake.
module hwd_watchdog #(
    parameter int unsigned TICK_CYCLES = hwd_pkg::TICK_CYCLES_DFLT
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // configuration
    input wire logic [7:0] i_slave_addr,
    // receive side
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_frame_end,
    // transmit side
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    output logic o_tx_frame_last,
    // status
    output logic o_expired,
    output logic o_enabled,
    output logic [7:0] o_period
);
    import hwd_pkg::*;

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("hwd_watchdog: TICK_CYCLES must be at least 2");
    end

    hwd_state_t state_r;
    logic [7:0] rx_buf_r [0:FRAME_LEN-1];
    logic [3:0] rx_cnt_r;
    logic rx_long_r;
    logic [15:0] rx_crc;
    logic [7:0] tx_buf_r [0:FRAME_LEN-1];
    logic [3:0] tx_len_r;
    logic [3:0] tx_idx_r;
    logic [7:0] tx_data_r;
    logic [15:0] tx_crc;
    logic tx_crc_step;
    logic enable_r;
    logic expired_r;
    logic [7:0] period_r;
    logic [31:0] tick_cnt_r;
    logic [7:0] elapsed_r;
    logic unit_tick;
    logic expire_evt;

    // decoded request fields
    logic [7:0] req_fc;
    logic [15:0] req_item;
    logic [15:0] req_val;
    logic addr_ok;
    logic frame_ok;
    logic take;

    // decode results
    logic [7:0] rsp [0:FRAME_LEN-1];
    logic [3:0] rsp_len;
    logic do_reply;
    logic do_kick;
    logic do_enable_wr;
    logic do_clear;
    logic do_period_wr;

    ////////////////////////////////////////////////////////////////////////////
    // receive collection; bytes during a reply are dropped since the line
    // is half duplex and anything heard then is not a request to us
    always_ff @(posedge i_clock) begin
        if (i_rst || i_rx_frame_end) begin
            rx_cnt_r <= 4'h0;
            rx_long_r <= 1'b0;
        end else if (i_rx_valid && state_r == ST_IDLE) begin
            if (rx_cnt_r < FRAME_LEN_B) begin
                rx_cnt_r <= rx_cnt_r + 4'h1;
            end else begin
                rx_long_r <= 1'b1; // oversize frames are never ours
            end
        end
    end

    // frame bytes held for decode
    always_ff @(posedge i_clock) begin
        if (i_rx_valid && state_r == ST_IDLE && rx_cnt_r < FRAME_LEN_B) begin
            rx_buf_r[rx_cnt_r[2:0]] <= i_rx_data;
        end
    end

    hwd_crc16 u_rx_crc (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clear(i_rx_frame_end),
        .i_valid(i_rx_valid && state_r == ST_IDLE),
        .i_data(i_rx_data),
        .o_crc(rx_crc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // request fields and frame acceptance
    assign req_fc = rx_buf_r[1];
    assign req_item = {rx_buf_r[2], rx_buf_r[3]};
    assign req_val = {rx_buf_r[4], rx_buf_r[5]};
    // broadcast and out-of-range addresses never match
    assign addr_ok = rx_buf_r[0] == i_slave_addr && i_slave_addr >= ADDR_MIN
        && i_slave_addr <= ADDR_MAX;
    assign frame_ok = rx_cnt_r == FRAME_LEN_B && !rx_long_r && rx_crc == CRC_RESIDUE;
    assign take = state_r == ST_IDLE && i_rx_frame_end && frame_ok && addr_ok;

    // per-function decode: reply bytes without crc and the side effects
    always_comb begin
        for (int i = 0; i < FRAME_LEN; i++) begin
            rsp[i] = 8'h00;
        end
        rsp[0] = i_slave_addr;
        rsp[1] = req_fc | FC_ERROR_FLAG;
        rsp[2] = EXC_FUNCTION;
        rsp_len = LEN_EXC;
        do_reply = 1'b1;
        do_kick = 1'b0;
        do_enable_wr = 1'b0;
        do_clear = 1'b0;
        do_period_wr = 1'b0;
        case (req_fc)
            FC_READ_BITS: begin
                if (req_item != ITEM_EXPIRY) begin
                    rsp[2] = EXC_ADDRESS;
                end else if (req_val != QTY_ONE) begin
                    rsp[2] = EXC_VALUE;
                end else begin
                    rsp[1] = req_fc;
                    rsp[2] = BYTES_FLAG;
                    rsp[3] = expired_r ? FLAG_SET_BYTE : FLAG_CLEAR_BYTE;
                    rsp_len = LEN_FLAG;
                end
            end
            FC_READ_HOLD, FC_READ_INPUT: begin
                if (req_item == REG_ALIVE && req_val == VAL_ALIVE) begin
                    do_kick = 1'b1;
                    do_reply = 1'b0;
                end else if (req_fc == FC_READ_HOLD && req_item == REG_PERIOD) begin
                    if (req_val != QTY_ONE) begin
                        rsp[2] = EXC_VALUE;
                    end else begin
                        rsp[1] = req_fc;
                        rsp[2] = BYTES_PERIOD;
                        rsp[3] = 8'h00;
                        rsp[4] = period_r;
                        rsp_len = LEN_PERIOD;
                    end
                end else begin
                    rsp[2] = EXC_ADDRESS;
                end
            end
            FC_WRITE_BIT: begin
                if (req_item == ITEM_ENABLE) begin
                    if (req_val == VAL_ON || req_val == VAL_OFF) begin
                        do_enable_wr = 1'b1;
                    end else begin
                        rsp[2] = EXC_VALUE;
                    end
                end else if (req_item == ITEM_EXPIRY) begin
                    if (req_val == VAL_ON) begin
                        do_clear = 1'b1;
                    end else begin
                        rsp[2] = EXC_VALUE;
                    end
                end else begin
                    rsp[2] = EXC_ADDRESS;
                end
                if (do_enable_wr || do_clear) begin
                    for (int i = 1; i < 6; i++) begin
                        rsp[i] = rx_buf_r[i];
                    end
                    rsp_len = LEN_ECHO;
                end
            end
            FC_WRITE_REG: begin
                if (req_item != REG_PERIOD) begin
                    rsp[2] = EXC_ADDRESS;
                end else if (req_val > PERIOD_MAX) begin
                    rsp[2] = EXC_VALUE;
                end else begin
                    do_period_wr = 1'b1;
                    for (int i = 1; i < 6; i++) begin
                        rsp[i] = rx_buf_r[i];
                    end
                    rsp_len = LEN_ECHO;
                end
            end
            default: begin
                rsp[2] = EXC_FUNCTION;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog settings
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            enable_r <= ENABLE_RST;
            period_r <= PERIOD_RST;
        end else if (take) begin
            if (do_enable_wr) begin
                enable_r <= req_val == VAL_ON;
            end
            if (do_period_wr) begin
                period_r <= req_val[7:0];
            end
        end
    end

    // unit prescaler and elapsed count; a notice, a change of enable or a
    // stopped timer restarts the count so a fresh period is always whole
    assign unit_tick = tick_cnt_r == TICK_CYCLES - 1;
    always_ff @(posedge i_clock) begin
        if (i_rst || !enable_r || expired_r || (take && (do_kick || do_enable_wr))) begin
            tick_cnt_r <= 32'h0;
            elapsed_r <= 8'h00;
        end else if (unit_tick) begin
            tick_cnt_r <= 32'h0;
            if (elapsed_r != 8'hff) begin
                elapsed_r <= elapsed_r + 8'h01;
            end
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // a zero period never expires; otherwise expire once it has elapsed
    assign expire_evt = enable_r && period_r != 8'h00 && elapsed_r >= period_r;

    // expiry flag: the event wins over a clear in the same cycle
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            expired_r <= 1'b0;
        end else if (expire_evt) begin
            expired_r <= 1'b1;
        end else if (take && do_clear) begin
            expired_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reply buffer, loaded in the cycle the request is taken
    always_ff @(posedge i_clock) begin
        if (take && do_reply) begin
            for (int i = 0; i < FRAME_LEN; i++) begin
                tx_buf_r[i] <= rsp[i];
            end
            tx_len_r <= rsp_len;
        end
    end

    // transmit sequencer: data bytes, then crc low, then crc high
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            tx_idx_r <= 4'h0;
            tx_data_r <= 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    tx_idx_r <= 4'h0;
                    if (take && do_reply) begin
                        state_r <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (tx_idx_r < tx_len_r) begin
                        tx_data_r <= tx_buf_r[tx_idx_r[2:0]];
                    end else if (tx_idx_r == tx_len_r) begin
                        tx_data_r <= tx_crc[7:0];
                    end else begin
                        tx_data_r <= tx_crc[15:8];
                    end
                    state_r <= ST_SEND;
                end
                ST_SEND: begin
                    if (i_tx_ready) begin
                        tx_idx_r <= tx_idx_r + 4'h1;
                        state_r <= o_tx_frame_last ? ST_IDLE : ST_LOAD;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // crc covers the data bytes only, folded in as each is accepted
    assign tx_crc_step = state_r == ST_SEND && i_tx_ready && tx_idx_r < tx_len_r;
    hwd_crc16 u_tx_crc (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clear(take),
        .i_valid(tx_crc_step),
        .i_data(tx_data_r),
        .o_crc(tx_crc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_tx_valid = state_r == ST_SEND;
    assign o_tx_data = tx_data_r;
    assign o_tx_frame_last = state_r == ST_SEND && tx_idx_r == tx_len_r + 4'h1;
    assign o_expired = expired_r;
    assign o_enabled = enable_r;
    assign o_period = period_r;

endmodule : hwd_watchdog

// ---- bench/hwd_watchdog_monitor.sv ----
// checker for the host watchdog command port, bound to its top module.
// assumes one clock and a synchronous active-high reset held two edges or more.
module hwd_watchdog_monitor #(
    parameter int unsigned TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // watched ports
    input wire logic [7:0] i_slave_addr,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_frame_end,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    input wire logic o_tx_frame_last,
    input wire logic o_expired,
    input wire logic o_enabled,
    input wire logic [7:0] o_period
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////
    // a reply opens two edges after the frame end that it answers
    sequence reply_open_s;
        i_rx_frame_end ##2 $rose(o_tx_valid);
    endsequence
    sequence byte_taken_s;
        o_tx_valid && i_tx_ready;
    endsequence
    ////////////////////////////////////////
    reply_addr_a: assert property (reply_open_s |-> o_tx_data == i_slave_addr)
        else $error("reply does not start with the slave address");
    reply_cause_a: assert property ($rose(o_tx_valid) |->
        $past(i_rx_frame_end, 2) || $past(o_tx_valid, 2)) else $error("reply byte without request");
    byte_hold_a: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_data)) else $error("reply byte dropped before accept");
    byte_gap_a: assert property (byte_taken_s |=> !o_tx_valid)
        else $error("no load cycle after accept");
    // nothing new can be due until a whole request has arrived again
    end_quiet_a: assert property (byte_taken_s and o_tx_frame_last |=> !o_tx_valid [*8])
        else $error("reply runs past its last byte");
    period_cause_a: assert property ($changed(o_period) |-> $past(i_rx_frame_end))
        else $error("period changed without a request");
    enable_cause_a: assert property ($changed(o_enabled) |-> $past(i_rx_frame_end))
        else $error("enable changed without a request");
    flag_clear_a: assert property ($fell(o_expired) |-> $past(i_rx_frame_end))
        else $error("expiry flag cleared without a request");
    flag_rise_a: assert property ($rose(o_expired) |->
        $past(o_enabled) && $past(o_period) != 8'h00) else $error("expiry while not armed");
endmodule : hwd_watchdog_monitor

bind hwd_watchdog hwd_watchdog_monitor #(.TICK_CYCLES(TICK_CYCLES)) hwd_watchdog_monitor_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_slave_addr(i_slave_addr), .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data), .i_rx_frame_end(i_rx_frame_end), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready), .o_tx_frame_last(o_tx_frame_last),
    .o_expired(o_expired), .o_enabled(o_enabled), .o_period(o_period));

// ---- bench/hwd_master_model.sv ----
// serial-link master model: sends whole requests, takes reply bytes.
// assumes the block's receive pulses and transmit handshake on one clock.
module hwd_master_model (
    // clock
    input wire logic i_clock,
    // to the block's receive side
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_frame_end,
    // from the block's transmit side
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_frame_last,
    output logic o_tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    bit slow = 1'b0;
    bit ended = 1'b0;
    logic [7:0] reply[$];
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h5a;
        o_rx_frame_end = 1'b0;
        o_tx_ready = 1'b0;
    end
    ////////////////////////////////////////
    // crc-16 of the link, kept apart from the block's own
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16
    // whole request, crc low byte first, then a gap and the frame end
    task automatic send(input logic [7:0] b[$]);
        logic [15:0] c;
        c = crc16(b);
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= b[i];
            @(posedge i_clock);
        end
        o_rx_valid <= 1'b0;
        o_rx_data <= ~c[15:8];   // released line must not show the last byte
        @(posedge i_clock);
        o_rx_frame_end <= 1'b1;
        @(posedge i_clock);
        o_rx_frame_end <= 1'b0;
    endtask : send
    // takes reply bytes until the last one; slow mode makes every byte wait one edge
    task automatic collect(input int limit);
        bit done;
        done = 1'b0;
        reply.delete();
        for (int n = 0; n < limit && !done; n++) begin
            @(posedge i_clock);
            if (i_tx_valid && o_tx_ready) begin
                reply.push_back(i_tx_data);
                done = i_tx_frame_last;
            end
            // ready, once raised, stands until the byte is taken
            o_tx_ready <= !done && (!slow || (i_tx_valid && !o_tx_ready));
        end
        ended = done;
    endtask : collect
endmodule : hwd_master_model

// ---- bench/hwd_watchdog_test.sv ----
// self-checking bench for the host watchdog command port.
// assumes the master model drives requests and takes replies.
`define CHECK(got, exp) \
    begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module hwd_watchdog_test;
    timeunit 1ns;
    timeprecision 1ps;
    import hwd_pkg::*;
    localparam int unsigned TICKS = 4;
    localparam logic [7:0] ADDR = 8'h11;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic rx_valid, rx_frame_end, tx_valid, tx_ready, tx_last, expired, enabled;
    logic [7:0] rx_data, tx_data, period;
    logic [7:0] none[$];
    logic [7:0] slave_addr = ADDR;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2 clock = ~clock;
    hwd_watchdog #(.TICK_CYCLES(TICKS)) hwd_watchdog_i (
        .i_clock(clock), .i_rst(rst), .i_slave_addr(slave_addr), .i_rx_valid(rx_valid),
        .i_rx_data(rx_data), .i_rx_frame_end(rx_frame_end), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_tx_frame_last(tx_last),
        .o_expired(expired), .o_enabled(enabled), .o_period(period));
    hwd_master_model hwd_master_model_i (
        .i_clock(clock), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .o_rx_frame_end(rx_frame_end), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .i_tx_frame_last(tx_last), .o_tx_ready(tx_ready));
    ////////////////////////////////////////
    // one request and its whole reply; an empty expectation means silence
    task automatic xfer(input logic [7:0] a, input logic [7:0] fc, input logic [15:0] item,
                        input logic [15:0] val, input logic [7:0] exp[$]);
        int want;
        want = exp.size() + (exp.size() != 0 ? 2 : 0);
        hwd_master_model_i.send('{a, fc, item[15:8], item[7:0], val[15:8], val[7:0]});
        hwd_master_model_i.collect(60);
        `CHECK(hwd_master_model_i.reply.size(), want);
        `CHECK(hwd_master_model_i.ended, exp.size() != 0);
        foreach (exp[i]) `CHECK(hwd_master_model_i.reply[i], exp[i]);
        if (exp.size() != 0) begin
            `CHECK(hwd_master_model_i.crc16(hwd_master_model_i.reply), 16'h0);
        end
    endtask : xfer
    task automatic echo(input logic [7:0] fc, input logic [15:0] item, input logic [15:0] val);
        xfer(ADDR, fc, item, val, '{ADDR, fc, item[15:8], item[7:0], val[15:8], val[7:0]});
    endtask : echo
    ////////////////////////////////////////
    task automatic t_reads();
        `CHECK(enabled, 1'b0);
        `CHECK(period, 8'h00);
        xfer(ADDR, 8'h01, 16'h010d, 16'h0001, '{ADDR, 8'h01, 8'h01, 8'h00});
        echo(8'h06, 16'h01e8, 16'h00ff);
        `CHECK(period, 8'hff);
        hwd_master_model_i.slow = 1'b1;
        xfer(ADDR, 8'h03, 16'h01e8, 16'h0001, '{ADDR, 8'h03, 8'h02, 8'h00, 8'hff});
        hwd_master_model_i.slow = 1'b0;
    endtask : t_reads
    // refused values, items and functions, then frames that are not ours
    task automatic t_faults();
        xfer(ADDR, 8'h06, 16'h01e8, 16'h0100, '{ADDR, 8'h86, 8'h03});
        xfer(ADDR, 8'h05, 16'h0104, 16'h1234, '{ADDR, 8'h85, 8'h03});
        xfer(ADDR, 8'h01, 16'h0104, 16'h0001, '{ADDR, 8'h81, 8'h02});
        xfer(ADDR, 8'h2b, 16'h0000, 16'h0001, '{ADDR, 8'hab, 8'h01});
        xfer(ADDR, 8'h04, 16'h01e8, 16'h0001, '{ADDR, 8'h84, 8'h02});
        xfer(ADDR, 8'h03, 16'h01e8, 16'h0002, '{ADDR, 8'h83, 8'h03});
        xfer(ADDR, 8'h05, 16'h010d, 16'h0000, '{ADDR, 8'h85, 8'h03});
        xfer(ADDR + 8'h01, 8'h06, 16'h01e8, 16'h0010, none);
        // an address above the slave range must never be answered, even when it matches
        slave_addr <= 8'hf8;
        xfer(8'hf8, 8'h06, 16'h01e8, 16'h0020, none);
        slave_addr <= ADDR;
        // a short frame is dropped whatever it holds
        hwd_master_model_i.send('{ADDR, 8'h06, 8'h01, 8'he8, 8'h00});
        hwd_master_model_i.collect(20);
        `CHECK(hwd_master_model_i.reply.size(), 0);
        `CHECK(period, 8'hff);
    endtask : t_faults
    // notices keep the timer quiet; silence lets it expire; flag holds until cleared
    task automatic t_timer();
        echo(8'h06, 16'h01e8, 16'h000c);
        echo(8'h05, 16'h0104, 16'hff00);
        `CHECK(enabled, 1'b1);
        for (int k = 0; k < 4; k++) begin
            hwd_master_model_i.send('{ADDR, k[0] ? 8'h04 : 8'h03, 8'h30, 8'h38, 8'h00, 8'h00});
            hwd_master_model_i.collect(6);
            `CHECK(hwd_master_model_i.reply.size(), 0);
        end
        repeat (20) @(posedge clock);
        `CHECK(expired, 1'b0);
        repeat (40) @(posedge clock);
        `CHECK(expired, 1'b1);
        xfer(ADDR, 8'h01, 16'h010d, 16'h0001, '{ADDR, 8'h01, 8'h01, 8'h01});
        echo(8'h05, 16'h0104, 16'h0000);
        `CHECK(enabled, 1'b0);
        `CHECK(expired, 1'b1);
        echo(8'h05, 16'h010d, 16'hff00);
        `CHECK(expired, 1'b0);
    endtask : t_timer
    ////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reads();
        t_faults();
        t_timer();
        conclude();
    end
endmodule : hwd_watchdog_test
